// file: tms_params.svh
/*
 * Constants of the temperature monitor status and configuration block: pointer values,
 * configuration field positions, reset values and timing figures.
 * Assumes it is included by bare name from files that need these values.
 */
`ifndef TMS_PARAMS_SVH
`define TMS_PARAMS_SVH

// Pointer values of the registers held in this block.
`define TMS_PTR_SECOND_STATUS 8'h22
`define TMS_PTR_OPEN_STATUS 8'h23
`define TMS_PTR_CONFIG 8'h30
`define TMS_PTR_RESET 8'h00

// Configuration register layout and power-on value.
`define TMS_CFG_RESET 16'h0f9c
`define TMS_CFG_REN_HI 15
`define TMS_CFG_REN_LO 8
`define TMS_CFG_LEN 7
`define TMS_CFG_OS 6
`define TMS_CFG_SD 5
`define TMS_CFG_CR_HI 4
`define TMS_CFG_CR_LO 2
`define TMS_CFG_BUSY 1
`define TMS_CFG_RSVD 0
`define TMS_RATE_CONT 3'h7
`define TMS_RATE_SHORTEST 3'h6

// Status register layouts.
`define TMS_STAT_REM_LO 8
`define TMS_STAT_LOC 7
`define TMS_STAT_ZERO_W 7
`define TMS_OPEN_ZERO_W 8

// Channel numbering: local is index 0, remote n is index n.
`define TMS_NUM_CH 9
`define TMS_CH_LOCAL 4'h0
`define TMS_CH_LAST 4'h8

// Shortest idle period (rate code 110) and the clock rate.
`define TMS_SHORT_PERIOD_MS 250
`define TMS_CLK_MHZ 200
`define TMS_SHORT_PERIOD_CYC (`TMS_SHORT_PERIOD_MS * `TMS_CLK_MHZ * 1000)

`endif

// file: tms_pkg.sv
/*
 * Types shared by the temperature monitor status and configuration block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tms_pkg;
	typedef enum logic [3:0] {
		TMS_ST_OFF = 4'b0001,
		TMS_ST_START = 4'b0010,
		TMS_ST_WAIT = 4'b0100,
		TMS_ST_IDLE = 4'b1000
	} tms_state_t;
endpackage

// file: tms_hyst_flag.sv
/*
 * One channel's second-level over-limit flag with hysteresis.
 * Assumes temperature and limit share one signed format and the hysteresis is unsigned.
 */
`timescale 1ns/10ps
`default_nettype none
module tms_hyst_flag #(
	parameter int TW = 16
) (
	input wire logic ref_clk_i, // Device clock.
	input wire logic rstn_i, // Asynchronous reset, active low.
	input wire logic upd_i, // New result for this channel.
	input wire logic signed [TW-1:0] temp_i, // Measured temperature.
	input wire logic signed [TW-1:0] limit_i, // Second-level limit.
	input wire logic [TW-1:0] hyst_i, // Shared hysteresis.
	output logic flag_o // Over-limit flag.
);
	logic signed [TW+1:0] temp_x;
	logic signed [TW+1:0] lim_x;
	logic signed [TW+1:0] rel_x;

	// Two guard bits keep limit minus hysteresis from wrapping.
	assign temp_x = {{2{temp_i[TW-1]}}, temp_i};
	assign lim_x = {{2{limit_i[TW-1]}}, limit_i};
	assign rel_x = lim_x - $signed({2'b00, hyst_i});

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flag_o <= 1'b0;
		end else if (upd_i) begin
			if (temp_x > lim_x) begin
				flag_o <= 1'b1;
			end else if (temp_x <= rel_x) begin
				flag_o <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// file: tms_chan_pick.sv
/*
 * Round-robin choice of the next enabled channel after the current one.
 * Assumes channel 0 is local and the rest remote in ascending order.
 */
`timescale 1ns/10ps
`default_nettype none
module tms_chan_pick #(
	parameter int N = 9
) (
	input wire logic [N-1:0] en_i, // Channel enables.
	input wire logic [3:0] cur_i, // Current channel.
	output logic [3:0] nxt_o, // Next enabled channel, wrapping.
	output logic last_o // No enabled channel after the current one in this pass.
);
	always_comb begin
		int idx;
		idx = 0;
		nxt_o = cur_i;
		last_o = 1'b1;
		// Walk from farthest to nearest so the nearest enabled channel wins.
		for (int k = N; k >= 1; k--) begin
			idx = (int'(cur_i) + k) % N;
			if (en_i[idx]) begin
				nxt_o = 4'(idx);
			end
			if ((int'(cur_i) + k < N) && en_i[int'(cur_i) + k]) begin
				last_o = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// file: tms_status_config.sv
/*
 * Status and configuration logic of a nine-channel temperature monitor: second-level
 * over-limit flags and alert, remote open-circuit flags, configuration register and
 * conversion sequencer. Assumes a two-wire front end that turns bus transactions into
 * pointer loads, register writes and register reads, and an ADC that converts one
 * channel per start and answers with a done pulse. Limits and hysteresis live elsewhere.
 */
// What this block does
// - Second-level status is read-only at pointer 22h; writes do nothing.
// - Status bits 15:8 remote 8..1 flags, bit 7 local, bits 6:0 zero.
// - A flag sets when its temperature exceeds its own second-level limit.
// - A flag clears itself at or below limit minus the shared hysteresis.
// - Alert is low while any flag is set, high when all clear.
// - Open-circuit status is read-only at pointer 23h.
// - Open bits 15:8 show remote 8..1 open; bits 7:0 read zero.
// - Open flags never drive the alert output.
// - Configuration register at pointer 30h, read-write, reset value 0x0F9C.
// - Bits 15:8 enable remote channels 8..1, reset to 0Fh (remote 4..1 on, 8..5 off).
// - Bit 7 enables the local channel, reset to one.
// - Writing one to bit 6 together with bit 5 starts one pass over enabled channels.
// - Bit 5 set shuts measurement down; resets to zero.
// - Bits 4:2 pick the conversion rate; reset to 111.
// - Bit 1 reads one while converting; writes to it are ignored.
// - Rate codes 000..110 give 16 s to 0.25 s periods; 111 back-to-back.
// - Shutdown aborts at once; leaving it resumes starting with the lowest enabled channel.
// - After a one-shot pass the device is back in shutdown.
// - Enabled channels visited round-robin local, remote 1..8, skipping disabled.
`timescale 1ns/10ps
`default_nettype none
`include "tms_params.svh"
module tms_status_config #(
	parameter int TW = 16,
	parameter int NCH = `TMS_NUM_CH,
	parameter longint SHORT_PERIOD_CYC = `TMS_SHORT_PERIOD_CYC
) (
	input wire logic ref_clk_i, // Device clock, 200 MHz.
	input wire logic rstn_i, // Asynchronous power-on reset, active low.
	input wire logic ptr_load_i, // Pulse: load pointer from reg_wdata_i[7:0].
	input wire logic reg_wr_i, // Pulse: write reg_wdata_i to the pointed register.
	input wire logic reg_rd_i, // Pulse: read the pointed register.
	input wire logic [15:0] reg_wdata_i, // Write data or pointer value.
	output logic [15:0] reg_rdata_o, // Read data, from a register.
	output logic reg_rvalid_o, // Pulse: reg_rdata_o is valid.
	output logic adc_start_o, // Pulse: convert channel adc_chan_o.
	output logic [3:0] adc_chan_o, // Channel under conversion.
	input wire logic adc_done_i, // Pulse: conversion finished.
	input wire logic signed [TW-1:0] adc_temp_i, // Result of the finished conversion.
	input wire logic adc_open_i, // Remote diode found open in that conversion.
	input wire logic [NCH*TW-1:0] second_limit_i, // Second-level limits, channel 0 lowest.
	input wire logic [TW-1:0] hyst_i, // Shared hysteresis value.
	output logic second_overtemp_alert_n_o // Second-level alert, active low.
);
	logic [7:0] ptr_q;
	logic [7:0] remote_channel_enables_q;
	logic local_channel_enable_q;
	logic single_pass_trigger_q;
	logic shutdown_request_q;
	logic [2:0] conversion_rate_select_q;
	tms_pkg::tms_state_t st_q;
	logic [3:0] chan_q;
	logic start_q;
	logic [31:0] timer_q;
	logic [NCH-1:0] en_all;
	logic [3:0] nxt_chan;
	logic last_chan;
	logic run;
	logic done_ok;
	logic pass_end;
	logic cfg_wr;
	logic [NCH-1:0] second_flag;
	logic [NCH-1:1] open_q;
	logic [15:0] cfg_view;
	logic [31:0] period_cyc;
	// A literal cannot be part-selected, so the power-on value is held as a constant first.
	localparam logic [15:0] CFG_RST = `TMS_CFG_RESET;

	// Idle period of a rate code: the shortest one doubled once per step below 110.
	function automatic logic [31:0] rate_period(input logic [2:0] code);
		logic [2:0] steps;
		steps = `TMS_RATE_SHORTEST - code;
		return 32'(SHORT_PERIOD_CYC) << steps;
	endfunction

	function automatic logic ptr_is(input logic [7:0] p, input logic [7:0] v);
		return p == v;
	endfunction

	assign en_all = {remote_channel_enables_q, local_channel_enable_q};
	assign run = !shutdown_request_q || single_pass_trigger_q;
	assign done_ok = (st_q == tms_pkg::TMS_ST_WAIT) && adc_done_i;
	assign pass_end = done_ok && last_chan;
	assign cfg_wr = reg_wr_i && ptr_is(ptr_q, `TMS_PTR_CONFIG);
	assign period_cyc = rate_period(conversion_rate_select_q);

	tms_chan_pick #(
		.N(NCH)
	) u_pick (
		.en_i(en_all),
		.cur_i(chan_q),
		.nxt_o(nxt_chan),
		.last_o(last_chan)
	);

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_flag
			tms_hyst_flag #(
				.TW(TW)
			) u_flag (
				.ref_clk_i(ref_clk_i),
				.rstn_i(rstn_i),
				.upd_i(done_ok && (chan_q == 4'(g))),
				.temp_i(adc_temp_i),
				.limit_i(second_limit_i[g*TW +: TW]),
				.hyst_i(hyst_i),
				.flag_o(second_flag[g])
			);
		end
		for (g = 1; g < NCH; g++) begin : g_open
			always_ff @(posedge ref_clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					open_q[g] <= 1'b0;
				end else if (done_ok && (chan_q == 4'(g))) begin
					open_q[g] <= adc_open_i;
				end
			end
		end
	endgenerate

	// The pointer only changes on a write transaction from the host.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ptr_q <= `TMS_PTR_RESET;
		end else if (ptr_load_i) begin
			ptr_q <= reg_wdata_i[7:0];
		end
	end

	// Configuration fields. A host write lands after the one-shot clear so a fresh
	// trigger written in the cycle the pass ends is not lost.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			remote_channel_enables_q <= CFG_RST[`TMS_CFG_REN_HI:`TMS_CFG_REN_LO];
			local_channel_enable_q <= CFG_RST[`TMS_CFG_LEN];
			single_pass_trigger_q <= CFG_RST[`TMS_CFG_OS];
			shutdown_request_q <= CFG_RST[`TMS_CFG_SD];
			conversion_rate_select_q <= CFG_RST[`TMS_CFG_CR_HI:`TMS_CFG_CR_LO];
		end else begin
			if (pass_end && single_pass_trigger_q) begin
				single_pass_trigger_q <= 1'b0;
			end
			if (cfg_wr) begin
				remote_channel_enables_q <= reg_wdata_i[`TMS_CFG_REN_HI:`TMS_CFG_REN_LO];
				local_channel_enable_q <= reg_wdata_i[`TMS_CFG_LEN];
				conversion_rate_select_q <= reg_wdata_i[`TMS_CFG_CR_HI:`TMS_CFG_CR_LO];
				if (reg_wdata_i[`TMS_CFG_REN_HI:`TMS_CFG_LEN] == '0) begin
					// With no channel enabled the device simply sits in shutdown.
					shutdown_request_q <= 1'b1;
					single_pass_trigger_q <= 1'b0;
				end else begin
					shutdown_request_q <= reg_wdata_i[`TMS_CFG_SD];
					// A one-shot only means something while shut down.
					single_pass_trigger_q <= reg_wdata_i[`TMS_CFG_OS] && reg_wdata_i[`TMS_CFG_SD];
				end
			end
		end
	end

	// Conversion sequencer. Dropping run leaves any conversion at once; a late done
	// from the ADC is then ignored because the sequencer no longer waits for it.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= tms_pkg::TMS_ST_OFF;
			chan_q <= `TMS_CH_LAST;
		end else if (!run) begin
			st_q <= tms_pkg::TMS_ST_OFF;
			chan_q <= `TMS_CH_LAST;
		end else begin
			unique case (st_q)
				tms_pkg::TMS_ST_OFF: begin
					st_q <= tms_pkg::TMS_ST_START;
				end
				tms_pkg::TMS_ST_START: begin
					st_q <= tms_pkg::TMS_ST_WAIT;
					chan_q <= nxt_chan;
				end
				tms_pkg::TMS_ST_WAIT: begin
					if (pass_end) begin
						chan_q <= `TMS_CH_LAST;
						if (single_pass_trigger_q) begin
							st_q <= tms_pkg::TMS_ST_OFF;
						end else if (conversion_rate_select_q == `TMS_RATE_CONT) begin
							st_q <= tms_pkg::TMS_ST_START;
						end else begin
							st_q <= tms_pkg::TMS_ST_IDLE;
						end
					end else if (adc_done_i) begin
						st_q <= tms_pkg::TMS_ST_START;
					end
				end
				tms_pkg::TMS_ST_IDLE: begin
					if (timer_q >= period_cyc - 32'h0000_0001) begin
						st_q <= tms_pkg::TMS_ST_START;
					end
				end
				default: begin
					st_q <= tms_pkg::TMS_ST_OFF;
				end
			endcase
		end
	end

	// Period timer runs from the start of a pass, so the idle time is what is left of
	// the period after the conversions; a pass longer than the period restarts at once.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			timer_q <= 32'h0000_0000;
		end else if (st_q == tms_pkg::TMS_ST_START && chan_q == `TMS_CH_LAST) begin
			timer_q <= 32'h0000_0001;
		end else if (timer_q != 32'hffff_ffff) begin
			timer_q <= timer_q + 32'h0000_0001;
		end
	end

	// ADC request: one pulse per channel, channel number held until the next start, or set to 8 at the end of a pass or on shutdown.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			start_q <= 1'b0;
		end else begin
			start_q <= run && (st_q == tms_pkg::TMS_ST_START);
		end
	end
	assign adc_start_o = start_q;
	assign adc_chan_o = chan_q;

	// Only temperature flags feed the alert; open-circuit flags stay out of it.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			second_overtemp_alert_n_o <= 1'b1;
		end else begin
			second_overtemp_alert_n_o <= ~|second_flag;
		end
	end

	assign cfg_view = {
		remote_channel_enables_q,
		local_channel_enable_q,
		single_pass_trigger_q,
		shutdown_request_q,
		conversion_rate_select_q,
		st_q == tms_pkg::TMS_ST_WAIT,
		1'b0
	};

	// Read port. Writes to the status pointers fall through cfg_wr and change nothing.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= 16'h0000;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				if (ptr_is(ptr_q, `TMS_PTR_SECOND_STATUS)) begin
					reg_rdata_o <= {second_flag[NCH-1:1], second_flag[0], {`TMS_STAT_ZERO_W{1'b0}}};
				end else if (ptr_is(ptr_q, `TMS_PTR_OPEN_STATUS)) begin
					reg_rdata_o <= {open_q, {`TMS_OPEN_ZERO_W{1'b0}}};
				end else if (ptr_is(ptr_q, `TMS_PTR_CONFIG)) begin
					reg_rdata_o <= cfg_view;
				end else begin
					reg_rdata_o <= 16'h0000;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: tms_status_config_properties.sv
/* Concurrent checks on the ports of the status and configuration block.
   Assumes one clock domain, the asynchronous active-low reset and the bind below. */
`timescale 1ns/10ps
`default_nettype none
module tms_status_config_properties (
	input wire logic ref_clk_i, // Device clock.
	input wire logic rstn_i, // Reset, active low.
	input wire logic ptr_load_i, // Pointer load pulse.
	input wire logic reg_wr_i, // Write pulse.
	input wire logic reg_rd_i, // Read pulse.
	input wire logic [15:0] reg_wdata_i, // Write data.
	input wire logic [15:0] reg_rdata_o, // Read data.
	input wire logic reg_rvalid_o, // Read answer.
	input wire logic adc_start_o, // Conversion start.
	input wire logic [3:0] adc_chan_o, // Channel converted.
	input wire logic adc_done_i, // Conversion done.
	input wire logic second_overtemp_alert_n_o // Alert, active low.
);
	logic [7:0] ptr_q;
	logic [7:0] rd_ptr_q;
	// The pointer is mirrored so read data can be judged by the register it came from.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ptr_q <= 8'h00;
		end else if (ptr_load_i) begin
			ptr_q <= reg_wdata_i[7:0];
		end
	end
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_ptr_q <= 8'h00;
		end else if (reg_rd_i) begin
			rd_ptr_q <= ptr_q;
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
	rdata_hold_a: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o)) else $error("read data moved");
	second_zero_a: assert property (reg_rvalid_o && rd_ptr_q == 8'h22 |-> reg_rdata_o[6:0] == 7'h00) else $error("st2");
	open_zero_a: assert property (reg_rvalid_o && rd_ptr_q == 8'h23 |-> reg_rdata_o[7:0] == 8'h00) else $error("open");
	cfg_bit0_a: assert property (reg_rvalid_o && rd_ptr_q == 8'h30 |-> !reg_rdata_o[0]) else $error("cfg bit0");
	chan_change_a: assert property ($changed(adc_chan_o) |-> adc_start_o || adc_chan_o == 4'h8) else $error("channel moved");
	shutdown_stop_a: assert property (reg_wr_i && ptr_q == 8'h30 && reg_wdata_i[6:5] == 2'b01 |-> ##3 !adc_start_o [*8])
		else $error("start in shutdown");
	alert_cause_a: assert property ($changed(second_overtemp_alert_n_o) |-> $past(adc_done_i, 2)) else $error("alert");
endmodule
bind tms_status_config tms_status_config_properties tms_status_config_properties_i (.ref_clk_i(ref_clk_i),
	.rstn_i(rstn_i), .ptr_load_i(ptr_load_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .adc_start_o(adc_start_o), .adc_chan_o(adc_chan_o),
	.adc_done_i(adc_done_i), .second_overtemp_alert_n_o(second_overtemp_alert_n_o));
`default_nettype wire

// file: tms_adc_model.sv
/* Behavioural converter answering start pulses with a done pulse and a result.
   Assumes the testbench supplies the temperature and open state of every channel. */
`timescale 1ns/10ps
`default_nettype none
module tms_adc_model (
	input wire logic ref_clk_i, // Device clock.
	input wire logic rstn_i, // Reset, active low.
	input wire logic start_i, // Start pulse.
	input wire logic [3:0] chan_i, // Channel to convert.
	input wire logic slow_i, // Long conversion time.
	input wire logic [143:0] temps_i, // Temperature per channel.
	input wire logic [8:0] opens_i, // Open diode per channel.
	output logic done_o, // Done pulse.
	output logic signed [15:0] temp_o, // Result.
	output logic open_o // Open indication.
);
	int cnt = 0;
	logic [3:0] ch = 4'h0;
	initial done_o = 1'b0;
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= 0;
			done_o <= 1'b0;
		end else begin
			done_o <= (cnt == 1);
			if (start_i) begin
				cnt <= slow_i ? 9 : 2;
				ch <= chan_i;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
		end
	end
	// Outside the done cycle the result lines are inverted, so stale data is never mistaken for valid.
	assign temp_o = done_o ? temps_i[ch * 16 +: 16] : ~temps_i[ch * 16 +: 16];
	assign open_o = done_o ? opens_i[ch] : ~opens_i[ch];
endmodule
`default_nettype wire

// file: testbench.sv
/* Self-checking bench of the status and configuration block with a converter model.
   Assumes the checker is bound from its own file and a short idle period of 64 cycles. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic ref_clk_i = 1'b0, rstn_i = 1'b0, ptr_load_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, slow = 1'b0;
	logic rvalid, start, done, open, alert_n;
	logic [15:0] wdata = 16'h0000, rdata;
	logic signed [15:0] temp;
	logic [3:0] chan;
	logic [3:0] chans[$];
	logic [143:0] temps = 144'h0;
	logic [8:0] opens = 9'h000;
	int stamps[$];
	int cyc = 0, bad_count = 0, total_checks = 0;
	tms_status_config #(.SHORT_PERIOD_CYC(64)) tms_status_config_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.ptr_load_i(ptr_load_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .adc_start_o(start), .adc_chan_o(chan), .adc_done_i(done), .adc_temp_i(temp),
		.adc_open_i(open), .second_limit_i({9{16'h0100}}), .hyst_i(16'h0010), .second_overtemp_alert_n_o(alert_n));
	tms_adc_model tms_adc_model_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .start_i(start), .chan_i(chan),
		.slow_i(slow), .temps_i(temps), .opens_i(opens), .done_o(done), .temp_o(temp), .open_o(open));
	initial forever #2.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		cyc++;
		if (start === 1'b1) begin
			chans.push_back(chan);
			stamps.push_back(cyc);
		end
	end
	task automatic give_verdict();
		if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic ld_ptr(input logic [7:0] p);
		@(negedge ref_clk_i);
		ptr_load_i = 1'b1;
		wdata = {8'h00, p};
		@(negedge ref_clk_i);
		ptr_load_i = 1'b0;
	endtask
	task automatic wr_reg(input logic [7:0] p, input logic [15:0] d);
		ld_ptr(p);
		reg_wr_i = 1'b1;
		wdata = d;
		@(negedge ref_clk_i);
		reg_wr_i = 1'b0;
	endtask
	task automatic rd_cmp(input string what, input logic [7:0] p, input logic [15:0] mask, input logic [15:0] exp);
		ld_ptr(p);
		reg_rd_i = 1'b1;
		@(negedge ref_clk_i);
		reg_rd_i = 1'b0;
		cmp16("rvalid", 16'h0001, {15'h0000, rvalid});
		cmp16(what, exp, rdata & mask);
	endtask
	task automatic wait_starts(input int k, input int lim);
		int n;
		n = 0;
		while (chans.size() < k && n < lim) begin
			@(negedge ref_clk_i);
			n++;
		end
		if (chans.size() < k) begin
			bad_count++;
			give_verdict();
		end
	endtask
	task automatic pass_over();
		chans.delete();
		stamps.delete();
		wait_starts(20, 600);
	endtask
	task automatic s_reset_ro();
		rd_cmp("cfg", 8'h30, 16'hfffd, 16'h0f9c);
		wr_reg(8'h22, 16'hffff);
		wr_reg(8'h23, 16'hffff);
		wr_reg(8'h55, 16'hffff);
		rd_cmp("st2", 8'h22, 16'hffff, 16'h0000);
		rd_cmp("open", 8'h23, 16'hffff, 16'h0000);
		rd_cmp("unmapped", 8'h55, 16'hffff, 16'h0000);
	endtask
	task automatic s_shutdown();
		wr_reg(8'h30, 16'h5a23);
		repeat (2) @(negedge ref_clk_i);
		chans.delete();
		repeat (40) @(negedge ref_clk_i);
		cmp16("starts", 16'h0000, 16'(chans.size()));
		rd_cmp("cfg", 8'h30, 16'hffff, 16'h5a20);
	endtask
	task automatic s_oneshot();
		slow = 1'b1;
		chans.delete();
		wr_reg(8'h30, 16'h0360);
		wait_starts(2, 200);
		repeat (60) @(negedge ref_clk_i);
		cmp16("starts", 16'h0002, 16'(chans.size()));
		cmp16("chan a", 16'h0001, {12'h000, chans[0]});
		cmp16("chan b", 16'h0002, {12'h000, chans[1]});
		rd_cmp("cfg", 8'h30, 16'hffff, 16'h0320);
		slow = 1'b0;
	endtask
	task automatic s_resume();
		chans.delete();
		wr_reg(8'h30, 16'hff9c);
		wait_starts(10, 400);
		for (int i = 0; i < 10; i++) begin
			cmp16("order", 16'(i % 9), {12'h000, chans[i]});
		end
	endtask
	task automatic s_flags();
		temps[3 * 16 +: 16] = 16'h0101;
		temps[4 * 16 +: 16] = 16'h0100;
		opens[5] = 1'b1;
		pass_over();
		rd_cmp("st2", 8'h22, 16'hffff, 16'h0400);
		rd_cmp("open", 8'h23, 16'hffff, 16'h1000);
		cmp16("alert", 16'h0000, {15'h0000, alert_n});
		temps[3 * 16 +: 16] = 16'h00f1;
		pass_over();
		rd_cmp("st2", 8'h22, 16'hffff, 16'h0400);
		temps[3 * 16 +: 16] = 16'h00f0;
		pass_over();
		rd_cmp("st2", 8'h22, 16'hffff, 16'h0000);
		cmp16("alert", 16'h0001, {15'h0000, alert_n});
		rd_cmp("open", 8'h23, 16'hffff, 16'h1000);
	endtask
	task automatic s_rate();
		for (int c = 6; c >= 0; c--) begin
			wr_reg(8'h30, {8'h00, 3'b100, 3'(c), 2'b00});
			chans.delete();
			stamps.delete();
			wait_starts(3, 3 * (64 << (6 - c)) + 100);
			cmp16("period", 16'(64 << (6 - c)), 16'(stamps[2] - stamps[1]));
		end
	endtask
	initial begin
		repeat (20) @(negedge ref_clk_i);
		rstn_i = 1'b1;
		s_reset_ro();
		s_shutdown();
		s_oneshot();
		s_resume();
		s_flags();
		s_rate();
		give_verdict();
	end
endmodule
`default_nettype wire
